//--- pbsp_mem.sv
/*
 * pbsp_mem: device end, a pipelined zero-turnaround burst sram model.
 * assumes: controller drives the pins on CLK; reset is a model aid only.
 */
`timescale 1ns/100ps
// Functional notes
// - inputs except oe, order, sleep sampled on clock
// - back to back reads and writes, no gap
// - advance_load_n low starts each new cycle
// - advance_load_n high steps internal burst counter
// - controller loads fresh address after deselect
// - clock_hold high freezes all registers except the sleep control
// - address latched when hold and advance low
// - read starts with write strobe high
// - read data appears from second edge
// - output drive enable high floats outputs asynchronously
// - write strobe low at edge, self-timed write
// - only lanes with low enable are written
// - write data follows address by two cycles
// - burst starts at external address, wraps after four
// - order select low linear, high interleaved
// - interleaved: start xor 0,1,2,3
// - linear: low bits plus one modulo four
// - sleep entered two cycles after request
// - resume two cycles after request drops
// - controller keeps sleep request low normally
// - order select held fixed
// - continue deselect only after explicit deselect; here a continue after reset (idle) deselects too
module pbsp_mem #(
    parameter int DEPTH_W = pbsp_pkg::ADDR_W
) (
    input  wire logic CLK,
    input  wire logic RST_N,
    pbsp_if.mem       BUS,
    output logic      ASLEEP
);
    import pbsp_pkg::*;

    // ****************************************
    // storage and pipeline state
    // ****************************************
    logic [DATA_W-1:0]    mem_array [0:(1<<DEPTH_W)-1];
    logic [ADDR_W-1:0]    base_reg;
    logic [BURST_W-1:0]   step_reg;
    pbsp_op_e             op_reg;
    logic [LANES-1:0]     lanes_reg;
    logic [ADDR_W-1:0]    wr_addr1_reg, wr_addr2_reg;
    logic [LANES-1:0]     wr_lanes1_reg, wr_lanes2_reg;
    logic                 wr_go1_reg, wr_go2_reg;
    logic [ADDR_W-1:0]    rd_addr_reg;
    logic                 rd_go_reg;
    logic [DATA_W-1:0]    dout_reg;
    logic                 drive_reg;
    logic [1:0]           sleep_cnt_reg, wake_cnt_reg;
    logic                 asleep_reg;

    pbsp_op_e             op_next;
    logic [ADDR_W-1:0]    base_next;
    logic [BURST_W-1:0]   step_next;
    logic [LANES-1:0]     lanes_next;
    logic [ADDR_W-1:0]    cur_addr;
    logic [BURST_W-1:0]   low_bits;
    logic                 live;
    logic [BURST_W-1:0]   step_inc;

    // a continue edge accesses the beat after the one last captured
    assign step_inc = step_reg + BURST_ONE;

    // sleeping or waking blocks new operations but keeps state
    assign live = !BUS.clock_hold && !asleep_reg && wake_cnt_reg == CNT_ZERO;

    always_comb begin
        // burst address generation, linear or interleaved
        if (BUS.burst_order_select == ORDER_INT) begin
            low_bits = base_reg[BURST_W-1:0] ^ step_inc;
        end else begin
            low_bits = base_reg[BURST_W-1:0] + step_inc;
        end
    end

    always_comb begin
        op_next   = op_reg;
        base_next = base_reg;
        step_next = step_reg;
        lanes_next = lanes_reg;
        cur_addr  = {base_reg[ADDR_W-1:BURST_W], low_bits};
        if (!BUS.advance_load_n) begin
            base_next = BUS.ext_addr_bus;
            step_next = '0;
            cur_addr  = BUS.ext_addr_bus;
            lanes_next = BUS.byte_lane_write_n;
            if (BUS.chip_select_n) begin
                op_next = PBSP_DESEL;
            end else if (BUS.write_strobe_n) begin
                op_next = PBSP_READ;
            end else begin
                op_next = PBSP_WRITE;
            end
        end else begin
            // continue: stay deselected if the last cycle was a deselect
            step_next = step_inc;
            cur_addr  = {base_reg[ADDR_W-1:BURST_W], low_bits};
            lanes_next = BUS.byte_lane_write_n;
            if (op_reg == PBSP_IDLE) begin
                op_next = PBSP_DESEL;
            end
        end
    end

    // ****************************************
    // command capture
    // ****************************************
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            op_reg    <= PBSP_IDLE;
            base_reg  <= '0;
            step_reg  <= '0;
            lanes_reg <= LANES_OFF;
        end else if (live) begin
            op_reg    <= op_next;
            base_reg  <= base_next;
            step_reg  <= step_next;
            lanes_reg <= lanes_next;
        end
    end

    // the address used at this edge; burst steps reuse the captured base
    logic is_rd, is_wr;
    logic [ADDR_W-1:0] use_addr;
    always_comb begin
        use_addr = BUS.advance_load_n ? cur_addr : BUS.ext_addr_bus;
        is_rd = live && (BUS.advance_load_n ? op_reg == PBSP_READ :
                 (!BUS.chip_select_n && BUS.write_strobe_n));
        is_wr = live && (BUS.advance_load_n ? op_reg == PBSP_WRITE :
                 (!BUS.chip_select_n && !BUS.write_strobe_n));
    end

    // ****************************************
    // late-late write pipeline
    // ****************************************
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_go1_reg    <= 1'b0;
            wr_go2_reg    <= 1'b0;
            wr_addr1_reg  <= '0;
            wr_addr2_reg  <= '0;
            wr_lanes1_reg <= LANES_OFF;
            wr_lanes2_reg <= LANES_OFF;
        end else if (!BUS.clock_hold) begin
            wr_go1_reg    <= is_wr;
            wr_addr1_reg  <= use_addr;
            wr_lanes1_reg <= BUS.byte_lane_write_n;
            wr_go2_reg    <= wr_go1_reg;
            wr_addr2_reg  <= wr_addr1_reg;
            wr_lanes2_reg <= wr_lanes1_reg;
        end
    end

    // data for the write arrives two edges after its address
    always_ff @(posedge CLK) begin
        if (!BUS.clock_hold && wr_go2_reg) begin
            for (int l = 0; l < LANES; l++) begin
                if (!wr_lanes2_reg[l]) begin
                    mem_array[wr_addr2_reg[DEPTH_W-1:0]][l*LANE_W +: LANE_W] <=
                        BUS.dq_in[l*LANE_W +: LANE_W];
                end
            end
        end
    end

    // ****************************************
    // read pipeline
    // ****************************************
    logic [DATA_W-1:0] fwd_word;
    always_comb begin
        // a write still in flight to the same word is forwarded
        fwd_word = mem_array[rd_addr_reg[DEPTH_W-1:0]];
        if (wr_go2_reg && wr_addr2_reg == rd_addr_reg) begin
            for (int l = 0; l < LANES; l++) begin
                if (!wr_lanes2_reg[l]) begin
                    fwd_word[l*LANE_W +: LANE_W] = BUS.dq_in[l*LANE_W +: LANE_W];
                end
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rd_go_reg   <= 1'b0;
            rd_addr_reg <= '0;
            dout_reg    <= '0;
            drive_reg   <= 1'b0;
        end else if (!BUS.clock_hold) begin
            rd_go_reg   <= is_rd;
            rd_addr_reg <= use_addr;
            drive_reg   <= rd_go_reg;
            if (rd_go_reg) begin
                dout_reg <= fwd_word;
            end
        end
    end

    assign BUS.dq_mem_out  = dout_reg;
    // the enable is gated outside the clock so it can cut the bus at once
    assign BUS.dq_mem_oe_n = !(drive_reg && !BUS.output_drive_n);

    // ****************************************
    // sleep control
    // ****************************************
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sleep_cnt_reg <= CNT_ZERO;
            wake_cnt_reg  <= CNT_ZERO;
            asleep_reg    <= 1'b0;
        end else if (BUS.sleep_request) begin
            wake_cnt_reg <= CNT_ZERO;
            if (sleep_cnt_reg == 2'(SLEEP_CYC - 1)) begin
                asleep_reg <= 1'b1;
            end else begin
                sleep_cnt_reg <= sleep_cnt_reg + CNT_ONE;
            end
        end else begin
            sleep_cnt_reg <= CNT_ZERO;
            if (asleep_reg) begin
                asleep_reg   <= 1'b0;
                wake_cnt_reg <= 2'(WAKE_CYC);
            end else if (wake_cnt_reg != CNT_ZERO) begin
                wake_cnt_reg <= wake_cnt_reg - CNT_ONE;
            end
        end
    end

    // mirrors asleep_reg so the output rises on the same edge, not one later
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ASLEEP <= 1'b0;
        end else if (!BUS.sleep_request) begin
            ASLEEP <= 1'b0;
        end else if (sleep_cnt_reg == 2'(SLEEP_CYC - 1)) begin
            ASLEEP <= 1'b1;
        end
    end
endmodule : pbsp_mem

//--- pbsp_pkg.sv
/*
 * pbsp_pkg: shared constants for the pipelined burst sram port.
 * assumes: both ends and the interface import it; single 25 MHz clock.
 */
package pbsp_pkg;
    localparam int ADDR_W     = 20;
    localparam int LANES      = 4;
    localparam int LANE_W     = 9;
    localparam int DATA_W     = LANES * LANE_W;
    localparam int BURST_W    = 2;
    localparam int SLEEP_CYC  = 2;
    localparam int WAKE_CYC   = 2;
    localparam logic [BURST_W-1:0] BURST_LAST = 2'h3;
    localparam logic [BURST_W-1:0] BURST_ONE  = 2'h1;
    localparam logic [1:0]         CNT_ZERO   = 2'h0;
    localparam logic [1:0]         CNT_ONE    = 2'h1;
    localparam logic [LANES-1:0]   LANES_OFF  = 4'hF;
    localparam logic               ORDER_LIN  = 1'b0;
    localparam logic               ORDER_INT  = 1'b1;

    typedef enum logic [1:0] {
        PBSP_IDLE  = 2'b00,
        PBSP_READ  = 2'b01,
        PBSP_WRITE = 2'b10,
        PBSP_DESEL = 2'b11
    } pbsp_op_e;
endpackage : pbsp_pkg

//--- pbsp_if.sv
/*
 * pbsp_if: pins between the memory controller and the burst sram.
 * assumes: the testbench resolves the shared data bus from both enables.
 */
`timescale 1ns/100ps
interface pbsp_if;
    import pbsp_pkg::*;
    logic                       clock_hold;
    logic                       advance_load_n;
    logic                       write_strobe_n;
    logic                       chip_select_n;
    logic [LANES-1:0]           byte_lane_write_n;
    logic [ADDR_W-1:0]          ext_addr_bus;
    logic                       output_drive_n;
    logic                       burst_order_select;
    logic                       sleep_request;
    logic [DATA_W-1:0]          dq_ctl_out;
    logic                       dq_ctl_oe_n;
    logic [DATA_W-1:0]          dq_mem_out;
    logic                       dq_mem_oe_n;
    logic [DATA_W-1:0]          dq_in;

    modport mem (
        input  clock_hold, advance_load_n, write_strobe_n, chip_select_n,
        input  byte_lane_write_n, ext_addr_bus, output_drive_n,
        input  burst_order_select, sleep_request, dq_in,
        output dq_mem_out, dq_mem_oe_n
    );
    modport ctl (
        output clock_hold, advance_load_n, write_strobe_n, chip_select_n,
        output byte_lane_write_n, ext_addr_bus, output_drive_n,
        output burst_order_select, sleep_request, dq_ctl_out, dq_ctl_oe_n,
        input  dq_in
    );
endinterface : pbsp_if

//--- pbsp_ctl.sv
/*
 * pbsp_ctl: controller end, turns user requests into sram pin cycles.
 * assumes: one request per cycle; data for a write given the cycle after the request.
 */
`timescale 1ns/100ps
module pbsp_ctl (
    input  wire logic                           CLK,
    input  wire logic                           RST_N,
    pbsp_if.ctl                                 BUS,
    input  wire logic                           REQ_VALID,
    input  wire pbsp_pkg::pbsp_op_e             REQ_OP,
    input  wire logic                           REQ_BURST,
    input  wire logic [pbsp_pkg::ADDR_W-1:0]    REQ_ADDR,
    input  wire logic [pbsp_pkg::LANES-1:0]     REQ_LANES_N,
    input  wire logic [pbsp_pkg::DATA_W-1:0]    REQ_WDATA,
    input  wire logic                           REQ_HOLD,
    input  wire logic                           REQ_SLEEP,
    input  wire logic                           ORDER_SEL,
    output logic                                REQ_READY,
    output logic                                RD_VALID,
    output logic [pbsp_pkg::DATA_W-1:0]         RD_DATA
);
    import pbsp_pkg::*;

    logic              rd1_reg, rd2_reg, wr1_reg, wr2_reg;
    logic [DATA_W-1:0] wd1_reg, wd2_reg;
    logic [1:0]        wake_reg;
    logic              slp_reg;
    logic              desel_reg;

    // ****************************************
    // request to pins
    // ****************************************
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            BUS.clock_hold        <= 1'b0;
            BUS.advance_load_n    <= 1'b0;
            BUS.write_strobe_n    <= 1'b1;
            BUS.chip_select_n     <= 1'b1;
            BUS.byte_lane_write_n <= LANES_OFF;
            BUS.ext_addr_bus      <= '0;
            desel_reg             <= 1'b1;
        end else begin
            BUS.clock_hold <= REQ_HOLD;
            if (REQ_VALID && REQ_READY && !REQ_HOLD) begin
                // a burst step after a deselect is turned into a fresh load
                BUS.advance_load_n    <= REQ_BURST && !desel_reg;
                BUS.chip_select_n     <= REQ_OP == PBSP_DESEL;
                BUS.write_strobe_n    <= REQ_OP != PBSP_WRITE;
                BUS.byte_lane_write_n <= REQ_LANES_N;
                BUS.ext_addr_bus      <= REQ_ADDR;
                desel_reg             <= REQ_OP == PBSP_DESEL;
            end else if (!REQ_HOLD) begin
                BUS.advance_load_n    <= 1'b0;
                BUS.chip_select_n     <= 1'b1;
                BUS.write_strobe_n    <= 1'b1;
                BUS.byte_lane_write_n <= LANES_OFF;
                desel_reg             <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            BUS.sleep_request      <= 1'b0;
            BUS.burst_order_select <= ORDER_LIN;
            BUS.output_drive_n     <= 1'b1;
            slp_reg                <= 1'b0;
            wake_reg               <= CNT_ZERO;
            REQ_READY              <= 1'b0;
        end else begin
            BUS.sleep_request      <= REQ_SLEEP;
            BUS.burst_order_select <= ORDER_SEL;
            slp_reg                <= REQ_SLEEP;
            // hold off new requests through the wake-up time
            if (slp_reg) begin
                wake_reg <= 2'(WAKE_CYC + 1);
            end else if (wake_reg != CNT_ZERO) begin
                wake_reg <= wake_reg - CNT_ONE;
            end
            REQ_READY          <= !REQ_SLEEP && !slp_reg && wake_reg <= CNT_ONE;
            BUS.output_drive_n <= !(rd1_reg || rd2_reg);
        end
    end

    // ****************************************
    // data pipeline: write data two cycles late
    // ****************************************
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rd1_reg         <= 1'b0;
            rd2_reg         <= 1'b0;
            wr1_reg         <= 1'b0;
            wr2_reg         <= 1'b0;
            wd1_reg         <= '0;
            wd2_reg         <= '0;
            BUS.dq_ctl_out  <= '0;
            BUS.dq_ctl_oe_n <= 1'b1;
            RD_VALID        <= 1'b0;
            RD_DATA         <= '0;
        end else if (!BUS.clock_hold) begin
            rd1_reg <= !BUS.chip_select_n && BUS.write_strobe_n
                       || BUS.advance_load_n && rd1_reg;
            wr1_reg <= !BUS.chip_select_n && !BUS.write_strobe_n
                       || BUS.advance_load_n && wr1_reg;
            wd1_reg <= REQ_WDATA;
            rd2_reg <= rd1_reg;
            wr2_reg <= wr1_reg;
            wd2_reg <= wd1_reg;
            BUS.dq_ctl_out  <= wd1_reg;
            BUS.dq_ctl_oe_n <= !wr1_reg;
            RD_VALID        <= rd2_reg;
            RD_DATA         <= BUS.dq_in;
        end else begin
            // one pulse per beat: a frozen pipeline must not repeat it
            RD_VALID        <= 1'b0;
        end
    end
endmodule : pbsp_ctl

//--- pbsp_properties.sv
/*
 * pbsp_properties: pin timing checks on the link between both ends.
 * assumes: tb instantiates it beside the interface; one clock domain.
 */
`timescale 1ns/100ps
module pbsp_properties
    import pbsp_pkg::*;
(
    input wire logic              CLK,
    input wire logic              RST_N,
    input wire logic              clock_hold,
    input wire logic              advance_load_n,
    input wire logic              write_strobe_n,
    input wire logic              chip_select_n,
    input wire logic [LANES-1:0]  byte_lane_write_n,
    input wire logic              output_drive_n,
    input wire logic              burst_order_select,
    input wire logic              sleep_request,
    input wire logic              dq_ctl_oe_n,
    input wire logic              dq_mem_oe_n,
    input wire logic [DATA_W-1:0] dq_mem_out
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    // ****************************************
    // pipeline timing
    // ****************************************
    AST_RD_MEM_DRIVES: assert property (!clock_hold && !advance_load_n && !chip_select_n
        && write_strobe_n && !sleep_request ##1 !clock_hold && !sleep_request
        ##1 !clock_hold && !sleep_request && !output_drive_n |-> !dq_mem_oe_n)
        else $error("read data not driven two edges after load");
    AST_WR_CTL_DRIVES: assert property (!clock_hold && !advance_load_n && !chip_select_n
        && !write_strobe_n && byte_lane_write_n != LANES_OFF && !sleep_request
        ##1 !clock_hold ##1 !clock_hold |-> !dq_ctl_oe_n)
        else $error("write data not presented two cycles after load");
    AST_DESEL_QUIET: assert property (!clock_hold && !advance_load_n && chip_select_n
        ##1 !clock_hold ##1 !clock_hold |-> dq_mem_oe_n && dq_ctl_oe_n)
        else $error("data bus driven after a deselect");
    AST_OE_ASYNC: assert property (output_drive_n |-> dq_mem_oe_n)
        else $error("memory drives while output enable is off");
    AST_NO_CONTENTION: assert property (!(!dq_ctl_oe_n && !dq_mem_oe_n))
        else $error("both ends drive the data bus");
    AST_HOLD_FREEZE: assert property (clock_hold |=> $stable(dq_mem_out))
        else $error("output register moved under clock hold");
    // the pin takes its level one edge after reset, so that edge is exempt
    AST_ORDER_STATIC: assert property ($past(RST_N, 2) |-> $stable(burst_order_select))
        else $error("burst order changed in operation");
    AST_WAKE_GAP: assert property ($fell(sleep_request) |-> dq_ctl_oe_n [*2])
        else $error("controller wrote during wake up");
endmodule : pbsp_properties

//--- tb.sv
/*
 * tb: both ends joined by the interface, random and corner traffic.
 * assumes: design package and interface compiled first.
 */
`timescale 1ns/100ps
module tb;
    import pbsp_pkg::*;
    logic              clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_burst = 1'b0;
    logic              req_hold = 1'b0, req_sleep = 1'b0, order_sel = ORDER_LIN;
    logic              req_ready, rd_valid, asleep;
    logic              desel_seen = 1'b1;
    pbsp_op_e          req_op = PBSP_IDLE, bop = PBSP_DESEL;
    logic [ADDR_W-1:0] req_addr = '0, bstart = '0;
    logic [LANES-1:0]  req_lanes_n = LANES_OFF;
    logic [DATA_W-1:0] req_wdata = '0, pend = '0, last_dq = '0, rd_data;
    logic [DATA_W-1:0] model [int];
    logic [DATA_W-1:0] expq [$];
    int                miscompares = 0, check_count = 0, cycles = 0, bidx = 0, k;

    always #20 clk = ~clk;
    pbsp_if bus_if ();
    // a released bus flips every cycle so stale data never looks valid
    assign bus_if.dq_in = !bus_if.dq_ctl_oe_n ? bus_if.dq_ctl_out :
                          !bus_if.dq_mem_oe_n ? bus_if.dq_mem_out : ~last_dq;
    always @(posedge clk) last_dq <= bus_if.dq_in;

    pbsp_mem #(.DEPTH_W(8)) pbsp_mem_inst (.CLK(clk), .RST_N(rst_n), .BUS(bus_if.mem),
        .ASLEEP(asleep));
    pbsp_ctl pbsp_ctl_inst (.CLK(clk), .RST_N(rst_n), .BUS(bus_if.ctl), .REQ_VALID(req_valid),
        .REQ_OP(req_op), .REQ_BURST(req_burst), .REQ_ADDR(req_addr), .REQ_LANES_N(req_lanes_n),
        .REQ_WDATA(req_wdata), .REQ_HOLD(req_hold), .REQ_SLEEP(req_sleep),
        .ORDER_SEL(order_sel), .REQ_READY(req_ready), .RD_VALID(rd_valid), .RD_DATA(rd_data));
    pbsp_properties pbsp_properties_inst (.CLK(clk), .RST_N(rst_n),
        .clock_hold(bus_if.clock_hold), .advance_load_n(bus_if.advance_load_n),
        .write_strobe_n(bus_if.write_strobe_n), .chip_select_n(bus_if.chip_select_n),
        .byte_lane_write_n(bus_if.byte_lane_write_n), .output_drive_n(bus_if.output_drive_n),
        .burst_order_select(bus_if.burst_order_select), .sleep_request(bus_if.sleep_request),
        .dq_ctl_oe_n(bus_if.dq_ctl_oe_n), .dq_mem_oe_n(bus_if.dq_mem_oe_n),
        .dq_mem_out(bus_if.dq_mem_out));

    // ****************************************
    // expectation helpers
    // ****************************************
    function automatic logic [ADDR_W-1:0] baddr(logic [ADDR_W-1:0] s, int i, logic o);
        return {s[ADDR_W-1:2], (o == ORDER_INT) ? s[1:0] ^ 2'(i) : s[1:0] + 2'(i)};
    endfunction : baddr
    function automatic logic [DATA_W-1:0] rnd();
        return DATA_W'({$urandom(), $urandom()});
    endfunction : rnd
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize

    // ****************************************
    // drivers
    // ****************************************
    task automatic issue(input pbsp_op_e op, input logic bu, input logic [ADDR_W-1:0] a,
                         input logic [LANES-1:0] ln, input logic [DATA_W-1:0] wd);
        logic [ADDR_W-1:0] ea;
        @(negedge clk);
        req_wdata = pend;
        req_valid = 1'b1;
        req_op = op;
        {req_burst, req_addr, req_lanes_n} = {bu, a, ln};
        // a stall without ready leaves a deselect on the pins
        while (req_ready !== 1'b1) begin
            desel_seen = 1'b1;
            @(negedge clk);
        end
        // a burst step after any deselect is sent as a fresh load
        if (!bu || desel_seen) begin
            bstart = a;
            bidx = 0;
            bop = op;
        end else bidx++;
        desel_seen = (op == PBSP_DESEL);
        ea = baddr(bstart, bidx, order_sel);
        if (bop == PBSP_WRITE)
            for (int l = 0; l < LANES; l++)
                if (!ln[l]) model[ea][l*LANE_W +: LANE_W] = wd[l*LANE_W +: LANE_W];
        if (bop == PBSP_READ) expq.push_back(model[ea]);
        pend = wd;
        @(posedge clk);
    endtask : issue
    task automatic idle(input int n, input logic h);
        repeat (n) begin
            @(negedge clk);
            {req_wdata, req_valid, req_hold} = {pend, 1'b0, h};
        end
        @(negedge clk);
        {req_valid, req_hold} = 2'b00;
        desel_seen = 1'b1;
    endtask : idle
    task automatic do_reset(input logic o);
        @(negedge clk);
        {rst_n, order_sel} = {1'b0, o};
        desel_seen = 1'b1;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
    endtask : do_reset

    always @(negedge clk)
        if (rst_n && rd_valid === 1'b1) begin
            if (expq.size() == 0) check(rd_data, 'x);
            else check(rd_data, expq.pop_front());
        end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            $display("MISMATCH t=%0t timeout", $time);
            summarize();
        end
    end

    initial begin
        void'($urandom(69));
        do_reset(ORDER_LIN);
        for (int i = 0; i < 32; i++) // back to back, write then read
            issue(i < 16 ? PBSP_WRITE : PBSP_READ, 1'b0, ADDR_W'(i % 16), 4'h0, rnd());
        $display("test preload done");
        for (int o = 0; o < 2; o++) begin
            idle(8, 1'b0);
            do_reset(o[0]);
            for (int s = 0; s < 4; s++)
                for (int b = 0; b < 12; b++) // wraps after the fourth beat
                    issue(b < 4 ? PBSP_WRITE : PBSP_READ, !(b == 0 || b == 4),
                          20'h0_0020 + ADDR_W'(s), 4'h0, rnd());
        end
        $display("test bursts done");
        issue(PBSP_DESEL, 1'b0, '0, LANES_OFF, rnd());
        idle(3, 1'b0);
        issue(PBSP_READ, 1'b1, '0, LANES_OFF, rnd());
        issue(PBSP_READ, 1'b0, 20'h0_0005, LANES_OFF, rnd());
        $display("test deselect done");
        for (int i = 0; i < 300; i++) begin
            k = $urandom_range(0, 9);
            if (k == 0) idle($urandom_range(1, 3), 1'b1);
            else if (k < 3 && bop != PBSP_DESEL) issue(bop, 1'b1, '0, 4'($urandom()), rnd());
            else if (k == 3) issue(PBSP_DESEL, 1'b0, '0, LANES_OFF, rnd());
            else issue(k[0] ? PBSP_READ : PBSP_WRITE, 1'b0, ADDR_W'($urandom_range(0, 15)),
                       4'($urandom()), rnd());
        end
        $display("test random done");
        idle(8, 1'b0);
        @(negedge clk);
        req_sleep = 1'b1;
        wait (bus_if.sleep_request === 1'b1);
        @(posedge clk);
        #1 check(DATA_W'(asleep), '0);
        @(posedge clk);
        #1 check(DATA_W'(asleep), DATA_W'(1));
        check(DATA_W'(req_ready), '0);
        @(negedge clk);
        req_sleep = 1'b0;
        wait (bus_if.sleep_request === 1'b0);
        @(posedge clk);
        #1 check(DATA_W'(req_ready), '0);
        for (int i = 0; i < 16; i++) issue(PBSP_READ, 1'b0, ADDR_W'(i), LANES_OFF, rnd());
        idle(8, 1'b0);
        check(DATA_W'(expq.size()), '0);
        $display("test sleep done");
        summarize();
    end
endmodule : tb
